// File: pwi_pkg.sv
// Shared constants and types of the port wake and interrupt block
package pwi_pkg;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam int          IDX_W        = 14;
	localparam logic [11:0] IDX_WAKE_EVT = 12'h013;
	localparam logic [11:0] IDX_WAKE_ENA = 12'h017;
	localparam logic [11:0] IDX_INT_STAT = 12'h01b;
	localparam logic [11:0] IDX_INT_MASK = 12'h01f;
	localparam logic [11:0] IDX_PEND     = 12'h001;
	localparam logic [11:0] IDX_PEND_MSK = 12'h002;

	// ------------------------------------------------------------
	// Field positions, reset values, bus answers
	// ------------------------------------------------------------
	localparam int         BIT_FRAME   = 2;
	localparam int         BIT_LINK    = 1;
	localparam int         BIT_ENERGY  = 0;
	localparam int         BIT_PTP     = 2;
	localparam int         BIT_PHY     = 1;
	localparam int         BIT_ACL     = 0;
	localparam logic [2:0] RST_FIELD   = 3'h0;
	localparam logic [7:0] RST_BYTE    = 8'h00;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register selected by an index
	typedef enum logic [2:0] {
		SEL_NONE, SEL_EVT, SEL_ENA, SEL_STAT,
		SEL_MASK, SEL_PEND, SEL_PMSK
	} pwi_sel_t;

	// Per-port events and pending flags
	typedef struct packed {
		logic wake_frame;
		logic link_up;
		logic energy;
		logic ptp_pend;
		logic phy_pend;
		logic acl_evt;
	} pwi_port_in_t;

	// Visible register state of one port
	typedef struct packed {
		logic [2:0] evt;
		logic [2:0] ena;
		logic [2:0] stat;
		logic [2:0] mask;
	} pwi_port_regs_t;

	// Register strobes from the bus slave
	typedef struct packed {
		logic             wr;
		logic [IDX_W-1:0] widx;
		logic [7:0]       wdata;
		logic             wstrb;
		logic             rd;
		logic [IDX_W-1:0] ridx;
	} pwi_req_t;

endpackage

// File: pwi_port.sv
// One port's wake flags, wake enables, interrupt status and mask
`timescale 1ns/100ps
`default_nettype none
module pwi_port #(
	parameter bit IS_PHY = 1'b1
) (
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    reset,
	// Event inputs
	input  wire pwi_pkg::pwi_port_in_t   ev_in,
	// One-cycle register write strobes
	input  wire logic                    wr_evt,
	input  wire logic                    wr_ena,
	input  wire logic                    wr_mask,
	input  wire logic [2:0]              wdata,
	// Register state and requests
	output var  pwi_pkg::pwi_port_regs_t regs,
	output var  logic                    wake_req,
	output var  logic                    irq_req,
	output var  logic                    new_evt
);
	import pwi_pkg::*;

	// Link and energy bits exist only behind a PHY
	localparam logic [2:0] PHY_BITS = IS_PHY ? 3'h7 : 3'h4;

	logic [2:0] evt_ff, nxt_evt;
	logic [2:0] ena_ff, nxt_ena;
	logic [2:0] mask_ff, nxt_mask;
	logic       acl_ff, nxt_acl;
	logic       acl_toggle;
	logic [2:0] evt_set;
	logic [2:0] stat;

	// Detected wake events
	always_comb begin
		evt_set             = RST_FIELD;
		evt_set[BIT_FRAME]  = ev_in.wake_frame;
		evt_set[BIT_LINK]   = IS_PHY & ev_in.link_up;
		evt_set[BIT_ENERGY] = IS_PHY & ev_in.energy;
	end

	// Next values; a new event beats a clear in the same cycle
	always_comb begin
		acl_toggle = wr_mask && (wdata[BIT_ACL] != mask_ff[BIT_ACL]);
		nxt_evt    = (evt_ff & ~(wr_evt ? wdata : RST_FIELD)) | evt_set;
		nxt_ena    = wr_ena ? (wdata & PHY_BITS) : ena_ff;
		nxt_mask   = wr_mask ? wdata : mask_ff;
		nxt_acl    = ev_in.acl_evt | (acl_ff & ~acl_toggle);
	end

	// State registers
	always_ff @(posedge clock) begin
		if (reset) begin
			evt_ff  <= RST_FIELD;
			ena_ff  <= RST_FIELD;
			mask_ff <= RST_FIELD;
			acl_ff  <= 1'b0;
		end else begin
			evt_ff  <= nxt_evt;
			ena_ff  <= nxt_ena;
			mask_ff <= nxt_mask;
			acl_ff  <= nxt_acl;
		end
	end

	// Timing and PHY bits mirror lower-level pending flags, only behind a PHY
	always_comb begin
		stat          = RST_FIELD;
		stat[BIT_PTP] = IS_PHY & ev_in.ptp_pend;
		stat[BIT_PHY] = IS_PHY & ev_in.phy_pend;
		stat[BIT_ACL] = acl_ff;
	end

	// Requests towards the shared wake pin and interrupt
	assign regs     = '{evt: evt_ff, ena: ena_ff, stat: stat, mask: mask_ff};
	assign wake_req = |(evt_ff & ena_ff);
	assign irq_req  = |(stat & ~mask_ff);
	assign new_evt  = |evt_set;

endmodule
`default_nettype wire

// File: pwi_axil.sv
// AXI4-Lite slave turning bus transfers into register strobes
`timescale 1ns/100ps
`default_nettype none
module pwi_axil (
	// Clock and reset
	input  wire logic                      clock,
	input  wire logic                      reset,
	// Write address and data
	input  wire logic [pwi_pkg::IDX_W+1:0] s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output var  logic                      s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output var  logic                      s_axi_wready,
	// Write response
	output var  logic [1:0]                s_axi_bresp,
	output var  logic                      s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	// Read address and data
	input  wire logic [pwi_pkg::IDX_W+1:0] s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output var  logic                      s_axi_arready,
	output var  logic [31:0]               s_axi_rdata,
	output var  logic [1:0]                s_axi_rresp,
	output var  logic                      s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Register side
	output var  pwi_pkg::pwi_req_t         req,
	input  wire logic                      wr_ok,
	input  wire logic                      rd_ok,
	input  wire logic [7:0]                rd_data
);
	import pwi_pkg::*;

	logic       awh_ff, nxt_awh, wh_ff, nxt_wh;
	logic       wbusy_ff, nxt_wbusy, rbusy_ff, nxt_rbusy;
	logic       awr_ff, nxt_awr, wr_ff, nxt_wr, arr_ff, nxt_arr;
	logic       bv_ff, nxt_bv, rv_ff, nxt_rv;
	logic [1:0] br_ff, nxt_br, rr_ff, nxt_rr;
	logic [7:0] rd_ff, nxt_rd;
	pwi_req_t   req_ff, nxt_req;

	// Handshakes; one write and one read in flight at most
	always_comb begin
		nxt_awh = awh_ff;  nxt_wh = wh_ff;
		nxt_wbusy = wbusy_ff;  nxt_rbusy = rbusy_ff;
		nxt_bv = bv_ff;  nxt_br = br_ff;
		nxt_rv = rv_ff;  nxt_rr = rr_ff;  nxt_rd = rd_ff;
		nxt_req = req_ff;
		nxt_req.wr = 1'b0;
		nxt_req.rd = 1'b0;
		if (s_axi_awvalid && awr_ff) begin
			nxt_awh      = 1'b1;
			nxt_req.widx = s_axi_awaddr[IDX_W+1:2];
		end
		if (s_axi_wvalid && wr_ff) begin
			nxt_wh        = 1'b1;
			nxt_req.wdata = s_axi_wdata[7:0];
			nxt_req.wstrb = s_axi_wstrb[0];
		end
		// Address and data may arrive in either order
		if (awh_ff && wh_ff) begin
			nxt_req.wr = 1'b1;
			nxt_awh    = 1'b0;
			nxt_wh     = 1'b0;
			nxt_wbusy  = 1'b1;
		end
		if (req_ff.wr) begin
			nxt_bv = 1'b1;
			nxt_br = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (bv_ff && s_axi_bready) begin
			nxt_bv    = 1'b0;
			nxt_wbusy = 1'b0;
		end
		if (s_axi_arvalid && arr_ff) begin
			nxt_req.rd   = 1'b1;
			nxt_req.ridx = s_axi_araddr[IDX_W+1:2];
			nxt_rbusy    = 1'b1;
		end
		if (req_ff.rd) begin
			nxt_rv = 1'b1;
			nxt_rd = rd_ok ? rd_data : RST_BYTE;
			nxt_rr = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (rv_ff && s_axi_rready) begin
			nxt_rv    = 1'b0;
			nxt_rbusy = 1'b0;
		end
		nxt_awr = !nxt_awh && !nxt_wbusy;
		nxt_wr  = !nxt_wh && !nxt_wbusy;
		nxt_arr = !nxt_rbusy;
	end

	// Bus state registers; ready stays low in the reset cycle
	always_ff @(posedge clock) begin
		if (reset) begin
			awh_ff <= 1'b0;  wh_ff <= 1'b0;
			wbusy_ff <= 1'b0;  rbusy_ff <= 1'b0;
			awr_ff <= 1'b0;  wr_ff <= 1'b0;  arr_ff <= 1'b0;
			bv_ff <= 1'b0;  br_ff <= RESP_OKAY;
			rv_ff <= 1'b0;  rr_ff <= RESP_OKAY;  rd_ff <= RST_BYTE;
			req_ff <= '0;
		end else begin
			awh_ff <= nxt_awh;  wh_ff <= nxt_wh;
			wbusy_ff <= nxt_wbusy;  rbusy_ff <= nxt_rbusy;
			awr_ff <= nxt_awr;  wr_ff <= nxt_wr;  arr_ff <= nxt_arr;
			bv_ff <= nxt_bv;  br_ff <= nxt_br;
			rv_ff <= nxt_rv;  rr_ff <= nxt_rr;  rd_ff <= nxt_rd;
			req_ff <= nxt_req;
		end
	end

	// Outputs straight from the flops; upper read bits are zero
	assign s_axi_awready = awr_ff;
	assign s_axi_wready  = wr_ff;
	assign s_axi_bvalid  = bv_ff;
	assign s_axi_bresp   = br_ff;
	assign s_axi_arready = arr_ff;
	assign s_axi_rvalid  = rv_ff;
	assign s_axi_rresp   = rr_ff;
	assign s_axi_rdata   = {24'h000000, rd_ff};
	assign req           = req_ff;

endmodule
`default_nettype wire

// File: pwi_top.sv
// Port wake events, wake pin and port interrupt status, top level
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module pwi_top #(
	parameter int                   NUM_PORTS = 3,
	parameter logic [NUM_PORTS-1:0] PHY_PORTS = 3'h3
) (
	// Clock and reset
	input  wire logic                                  clock,
	input  wire logic                                  reset,
	// AXI4-Lite write address and data
	input  wire logic [pwi_pkg::IDX_W+1:0]             s_axi_awaddr,
	input  wire logic                                  s_axi_awvalid,
	output var  logic                                  s_axi_awready,
	input  wire logic [31:0]                           s_axi_wdata,
	input  wire logic [3:0]                            s_axi_wstrb,
	input  wire logic                                  s_axi_wvalid,
	output var  logic                                  s_axi_wready,
	// AXI4-Lite write response
	output var  logic [1:0]                            s_axi_bresp,
	output var  logic                                  s_axi_bvalid,
	input  wire logic                                  s_axi_bready,
	// AXI4-Lite read
	input  wire logic [pwi_pkg::IDX_W+1:0]             s_axi_araddr,
	input  wire logic                                  s_axi_arvalid,
	output var  logic                                  s_axi_arready,
	output var  logic [31:0]                           s_axi_rdata,
	output var  logic [1:0]                            s_axi_rresp,
	output var  logic                                  s_axi_rvalid,
	input  wire logic                                  s_axi_rready,
	// Per-port events from the core, same clock
	input  wire pwi_pkg::pwi_port_in_t [NUM_PORTS-1:0] port_in,
	// Wake pin and interrupt
	output var  logic                                  wake_output_pin,
	output var  logic                                  irq
);
	import pwi_pkg::*;

	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	pwi_req_t                        req;
	pwi_sel_t                        wr_sel;
	pwi_sel_t                        rd_sel;
	logic                            wr_ok;
	logic                            rd_ok;
	logic [7:0]                      rd_data;
	logic [NUM_PORTS-1:0]            wr_evt;
	logic [NUM_PORTS-1:0]            wr_ena;
	logic [NUM_PORTS-1:0]            wr_mask;
	logic                            wr_pmsk;
	logic                            pend_clr;
	pwi_port_regs_t [NUM_PORTS-1:0]  regs;
	logic [NUM_PORTS-1:0]            wake_req;
	logic [NUM_PORTS-1:0]            irq_req;
	logic [NUM_PORTS-1:0]            new_evt;
	logic [NUM_PORTS-1:0]            pend_ff, nxt_pend;
	logic [NUM_PORTS-1:0]            pmsk_ff, nxt_pmsk;
	logic                            wake_ff, nxt_wake;
	logic                            irq_ff, nxt_irq;

	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------

	// Port field zero holds the summary registers
	function automatic pwi_sel_t pwi_dec(input logic [IDX_W-1:0] idx);
		logic [11:0] off;
		logic [1:0]  num;
		off     = idx[11:0];
		num     = idx[IDX_W-1:12];
		pwi_dec = SEL_NONE;
		if (num == 2'h0) begin
			if (off == IDX_PEND)
				pwi_dec = SEL_PEND;
			else if (off == IDX_PEND_MSK)
				pwi_dec = SEL_PMSK;
		end else if (int'(num) <= NUM_PORTS) begin
			case (off)
				IDX_WAKE_EVT: pwi_dec = SEL_EVT;
				IDX_WAKE_ENA: pwi_dec = SEL_ENA;
				IDX_INT_STAT: pwi_dec = SEL_STAT;
				IDX_INT_MASK: pwi_dec = SEL_MASK;
				default:      pwi_dec = SEL_NONE;
			endcase
		end
	endfunction

	// Write strobes; lane 0 must be enabled for any effect
	always_comb begin
		wr_sel  = pwi_dec(req.widx);
		wr_ok   = wr_sel != SEL_NONE;
		wr_evt  = '0;
		wr_ena  = '0;
		wr_mask = '0;
		wr_pmsk = req.wr && req.wstrb && wr_sel == SEL_PMSK;
		for (int p = 0; p < NUM_PORTS; p++) begin
			if (req.wr && req.wstrb &&
			    req.widx[IDX_W-1:12] == 2'(p + 1)) begin
				wr_evt[p]  = wr_sel == SEL_EVT;
				wr_ena[p]  = wr_sel == SEL_ENA;
				wr_mask[p] = wr_sel == SEL_MASK;
			end
		end
	end

	// ------------------------------------------------------------
	// Bus slave and port instances
	// ------------------------------------------------------------
	pwi_axil u_axil (
		.clock         (clock),
		.reset         (reset),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.req           (req),
		.wr_ok         (wr_ok),
		.rd_ok         (rd_ok),
		.rd_data       (rd_data)
	);

	// One register set per port
	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
		pwi_port #(
			.IS_PHY (PHY_PORTS[p])
		) u_port (
			.clock    (clock),
			.reset    (reset),
			.ev_in    (port_in[p]),
			.wr_evt   (wr_evt[p]),
			.wr_ena   (wr_ena[p]),
			.wr_mask  (wr_mask[p]),
			.wdata    (req.wdata[2:0]),
			.regs     (regs[p]),
			.wake_req (wake_req[p]),
			.irq_req  (irq_req[p]),
			.new_evt  (new_evt[p])
		);
	end

	// ------------------------------------------------------------
	// Summary flags, wake pin and interrupt
	// ------------------------------------------------------------

	// A new wake event wins over a clearing read
	always_comb begin
		pend_clr = req.rd && rd_sel == SEL_PEND;
		nxt_pend = (pend_ff & ~{NUM_PORTS{pend_clr}}) | new_evt;
		nxt_pmsk = wr_pmsk ? req.wdata[NUM_PORTS-1:0] : pmsk_ff;
		nxt_wake = |wake_req;
		nxt_irq  = (|irq_req) | (|(pend_ff & ~pmsk_ff));
	end

	// Pins come from flops, one cycle behind their cause
	always_ff @(posedge clock) begin
		if (reset) begin
			pend_ff <= '0;
			pmsk_ff <= '0;
			wake_ff <= 1'b0;
			irq_ff  <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
			pmsk_ff <= nxt_pmsk;
			wake_ff <= nxt_wake;
			irq_ff  <= nxt_irq;
		end
	end

	assign wake_output_pin = wake_ff;
	assign irq             = irq_ff;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------

	// Reserved bits read as zero
	always_comb begin
		rd_sel  = pwi_dec(req.ridx);
		rd_ok   = rd_sel != SEL_NONE;
		rd_data = RST_BYTE;
		case (rd_sel)
			SEL_PEND: rd_data = 8'(pend_ff);
			SEL_PMSK: rd_data = 8'(pmsk_ff);
			default: begin
				for (int p = 0; p < NUM_PORTS; p++) begin
					if (req.ridx[IDX_W-1:12] == 2'(p + 1)) begin
						case (rd_sel)
							SEL_EVT:  rd_data = 8'(regs[p].evt);
							SEL_ENA:  rd_data = 8'(regs[p].ena);
							SEL_STAT: rd_data = 8'(regs[p].stat);
							SEL_MASK: rd_data = 8'(regs[p].mask);
							default:  rd_data = RST_BYTE;
						endcase
					end
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	for (genvar p = 0; p < NUM_PORTS; p++) begin : g_chk
		// Wake flags, and PHY-only bits on MAC ports
		a_frame_sets_flag: assert property (
			port_in[p].wake_frame |=> regs[p].evt[BIT_FRAME]
		) else $error("wake frame did not set flag");
		if (PHY_PORTS[p]) begin : g_phy
			a_link_sets_flag: assert property (
				port_in[p].link_up |=> regs[p].evt[BIT_LINK]
			) else $error("link up did not set flag");
			a_energy_sets_flag: assert property (
				port_in[p].energy |=> regs[p].evt[BIT_ENERGY]
			) else $error("energy did not set flag");
		end else begin : g_mac
			a_mac_no_phy: assert property (
				regs[p].evt[1:0] == 2'h0 && regs[p].stat[2:1] == 2'h0
			) else $error("PHY-only bit set on MAC port");
		end
		a_flag_holds: assert property (
			regs[p].evt[BIT_FRAME] &&
			!(wr_evt[p] && req.wdata[BIT_FRAME])
			|=> regs[p].evt[BIT_FRAME]
		) else $error("wake flag dropped without clear");
		a_flag_clears: assert property (
			wr_evt[p] && req.wdata[BIT_FRAME] && !port_in[p].wake_frame
			|=> !regs[p].evt[BIT_FRAME]
		) else $error("wake flag not cleared by write");
		// Wake pin from enabled flags
		a_wake_pin_set: assert property (
			(regs[p].evt & regs[p].ena) != RST_FIELD
			|=> wake_output_pin
		) else $error("enabled flag did not drive wake pin");
		// Access list status and mirrored timing and PHY bits
		a_acl_sets: assert property (
			port_in[p].acl_evt |=> regs[p].stat[BIT_ACL]
		) else $error("access list event lost");
		a_acl_toggle_clr: assert property (
			wr_mask[p] && !port_in[p].acl_evt &&
			req.wdata[BIT_ACL] != regs[p].mask[BIT_ACL]
			|=> !regs[p].stat[BIT_ACL]
		) else $error("mask toggle did not clear status");
		a_acl_sticky: assert property (
			regs[p].stat[BIT_ACL] && !wr_mask[p]
			|=> regs[p].stat[BIT_ACL] [*1]
		) else $error("access list status dropped");
		a_lower_mirror: assert property (
			regs[p].stat[2:1] == (PHY_PORTS[p] ?
			{port_in[p].ptp_pend, port_in[p].phy_pend} : 2'h0)
		) else $error("status does not follow pending flags");
		// Interrupt gating by mask
		a_irq_unmasked: assert property (
			(regs[p].stat & ~regs[p].mask) != RST_FIELD |=> irq
		) else $error("unmasked status did not raise irq");
	end

	a_wake_pin_idle: assert property (
		wake_req == '0 |=> !wake_output_pin
	) else $error("wake pin high without enabled flag");
	a_irq_masked: assert property (
		irq_req == '0 && (pend_ff & ~pmsk_ff) == '0 |=> !irq
	) else $error("irq high with all sources masked");
	a_pend_read_clr: assert property (
		pend_clr && new_evt == '0 |=> pend_ff == '0
	) else $error("summary read did not clear");

	// Main scenarios
	c_wake_rise: cover property ($rose(wake_output_pin));
	c_irq_rise:  cover property ($rose(irq));
	c_acl_clear: cover property (
		regs[NUM_PORTS-1].stat[BIT_ACL] ##1
		!regs[NUM_PORTS-1].stat[BIT_ACL]);
	c_pend_read: cover property (pend_clr && pend_ff != '0);

endmodule
`default_nettype wire

// File: tb_top.sv
// Register-level testbench of the port wake and interrupt block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import pwi_pkg::*;
	// Bus and pin signals
	logic                  clock = 1'b0;
	logic                  reset = 1'b1;
	logic [15:0]           awaddr = '0;
	logic [15:0]           araddr = '0;
	logic [31:0]           wdata = '0;
	logic                  awvalid = 0, wvalid = 0, bready = 0;
	logic                  arvalid = 0, rready = 0;
	logic                  awready, wready, bvalid, arready, rvalid;
	logic [1:0]            bresp, rresp, brsp, rrsp;
	logic [31:0]           rdata, rdat;
	pwi_port_in_t [2:0]    port_in = '0;
	logic                  wake_output_pin, irq;
	int                    errors = 0, checked = 0, cyc = 0;

	pwi_top dut (
		.clock           (clock),
		.reset           (reset),
		.s_axi_awaddr    (awaddr),
		.s_axi_awvalid   (awvalid),
		.s_axi_awready   (awready),
		.s_axi_wdata     (wdata),
		.s_axi_wstrb     (4'h1),
		.s_axi_wvalid    (wvalid),
		.s_axi_wready    (wready),
		.s_axi_bresp     (bresp),
		.s_axi_bvalid    (bvalid),
		.s_axi_bready    (bready),
		.s_axi_araddr    (araddr),
		.s_axi_arvalid   (arvalid),
		.s_axi_arready   (arready),
		.s_axi_rdata     (rdata),
		.s_axi_rresp     (rresp),
		.s_axi_rvalid    (rvalid),
		.s_axi_rready    (rready),
		.port_in         (port_in),
		.wake_output_pin (wake_output_pin),
		.irq             (irq)
	);

	// 25 MHz core clock
	always #20 clock = ~clock;

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h",
				$time, got, exp);
		end
	endtask

	// Port n register byte address; index is n<<12 | offset
	function automatic logic [15:0] ad(input int n, input logic [11:0] o);
		return {n[1:0], o, 2'b00};
	endfunction

	// Address and data offered together, each released when taken
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clock);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge clock); while (bvalid !== 1'b1);
		brsp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [15:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clock); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge clock); while (rvalid !== 1'b1);
		rdat = rdata;
		rrsp = rresp;
		rready <= 1'b0;
	endtask

	task automatic rc(input logic [15:0] a, input logic [7:0] e);
		rd(a);
		chk(rdat, {24'h0, e});
	endtask

	// One-cycle event, then let flags and pins settle
	task automatic pulse(input int p, input logic [5:0] m);
		@(posedge clock);
		port_in[p] <= m;
		@(posedge clock);
		port_in[p] <= '0;
		repeat (3) @(posedge clock);
	endtask

	// Pins lag their cause by one registered stage
	task automatic pins(input logic [1:0] e);
		repeat (2) @(posedge clock);
		chk({30'h0, wake_output_pin, irq}, {30'h0, e});
	endtask

	task automatic report_and_stop;
		$display("errors %0d, checked %0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Hang guard; tests need well under a thousand cycles
	always @(posedge clock) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			report_and_stop;
		end
	end

	// Main sequence
	initial begin
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		rc(ad(1, IDX_WAKE_EVT), RST_BYTE);
		rc(ad(1, IDX_WAKE_ENA), RST_BYTE);
		rc(ad(1, IDX_INT_STAT), RST_BYTE);
		rc(ad(1, IDX_INT_MASK), RST_BYTE);
		// Summary pending kept out of irq
		wr(ad(0, IDX_PEND_MSK), 8'h07);
		pulse(0, 6'h20);
		rc(ad(1, IDX_WAKE_EVT), 8'h04);
		pins(2'b00);
		wr(ad(1, IDX_WAKE_ENA), 8'h04);
		pins(2'b10);
		wr(ad(1, IDX_WAKE_EVT), 8'h03);
		rc(ad(1, IDX_WAKE_EVT), 8'h04);
		wr(ad(1, IDX_WAKE_EVT), 8'h04);
		rc(ad(1, IDX_WAKE_EVT), 8'h00);
		pins(2'b00);
		rc(ad(0, IDX_PEND), 8'h01);
		rc(ad(0, IDX_PEND), 8'h00);
		// Link and energy, PHY port then MAC port
		pulse(1, 6'h18);
		rc(ad(2, IDX_WAKE_EVT), 8'h03);
		pins(2'b00);
		wr(ad(2, IDX_WAKE_ENA), 8'h02);
		pins(2'b10);
		wr(ad(2, IDX_WAKE_ENA), 8'h01);
		pins(2'b10);
		wr(ad(2, IDX_WAKE_EVT), 8'h03);
		pins(2'b00);
		pulse(2, 6'h18);
		rc(ad(3, IDX_WAKE_EVT), 8'h00);
		// Live timing and PHY status
		@(posedge clock);
		port_in[0] <= 6'h06;
		port_in[2] <= 6'h06;
		rc(ad(1, IDX_INT_STAT), 8'h06);
		rc(ad(3, IDX_INT_STAT), 8'h00);
		pins(2'b01);
		wr(ad(1, IDX_INT_MASK), 8'h06);
		pins(2'b00);
		port_in[0] <= '0;
		port_in[2] <= '0;
		// Access list status, cleared by mask toggle only
		pulse(2, 6'h01);
		rc(ad(3, IDX_INT_STAT), 8'h01);
		pins(2'b01);
		wr(ad(3, IDX_INT_MASK), 8'h01);
		rc(ad(3, IDX_INT_STAT), 8'h00);
		pulse(2, 6'h01);
		wr(ad(3, IDX_INT_MASK), 8'h01);
		rc(ad(3, IDX_INT_STAT), 8'h01);
		pins(2'b00);
		wr(ad(3, IDX_INT_MASK), 8'h00);
		rc(ad(3, IDX_INT_STAT), 8'h00);
		// Summary pending of port 2 now reaches irq
		wr(ad(0, IDX_PEND_MSK), 8'h00);
		pins(2'b01);
		rc(ad(0, IDX_PEND_MSK), 8'h00);
		rc(ad(0, IDX_PEND), 8'h02);
		pins(2'b00);
		// Unmapped place answers with an error
		rc(ad(1, 12'h020), 8'h00);
		chk({30'h0, rrsp}, {30'h0, RESP_SLVERR});
		wr(ad(1, 12'h020), 8'hff);
		chk({30'h0, brsp}, {30'h0, RESP_SLVERR});
		report_and_stop;
	end
endmodule
`default_nettype wire
